/* vrim_pkg.sv */
package vrim_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int XLEN = 32;
  localparam int NREG = 128;
  localparam int RIDX_W = 7;
  localparam int NSLOT = 5;
  localparam int NLD = 2;
  localparam int NRD = 3 * NSLOT;
  localparam int NLANE = NSLOT + NLD;
  localparam int WB_LIMIT = 5;
  localparam int ADD_LAT_CYC = 1;
  localparam int LD_LAT_CYC = 3;
  localparam logic [1:0] BR_DELAY_SLOTS = 2'h3;

  // ----------------------------------------------------------------
  // Reset values, vectors and status bit positions
  // ----------------------------------------------------------------
  localparam logic [31:0] PSW_RESET = 32'h0000_0800;
  localparam int PSW_CS_BIT = 11;
  localparam int PSW_WBE_BIT = 12;
  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [31:0] EXC_VECTOR = 32'h0000_0100;
  localparam logic [31:0] INSTR_STEP = 32'h0000_0020;
  localparam logic [31:0] CONST_ZERO = 32'h0000_0000;
  localparam logic [31:0] CONST_ONE = 32'h0000_0001;
  localparam logic [63:0] TALLY_RESET = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // Special register selects (immediate of move operations)
  // ----------------------------------------------------------------
  localparam logic [8:0] SEL_PSW = 9'h000;
  localparam logic [8:0] SEL_RESUME = 9'h001;
  localparam logic [8:0] SEL_BLOCK = 9'h002;
  localparam logic [8:0] SEL_TALLY_LO = 9'h003;
  localparam logic [8:0] SEL_TALLY_HI = 9'h004;

  // ----------------------------------------------------------------
  // Operation slot encoding and branch sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP, OP_IADD, OP_WORD_LOAD_DISP, OP_JMPF, OP_RDSPEC, OP_WRSPEC
  } vrim_op_e;

  typedef struct packed {
    vrim_op_e op;
    logic [RIDX_W-1:0] guard;
    logic [RIDX_W-1:0] src1;
    logic [RIDX_W-1:0] src2;
    logic [RIDX_W-1:0] dst;
    logic [8:0] imm;
  } vrim_slot_s;

  localparam int SLOT_W = $bits(vrim_slot_s);

  typedef enum logic {BR_IDLE, BR_DELAY} vrim_br_e;

endpackage : vrim_pkg

/* vrim_rf_if.sv */
`timescale 1ns/1ps
interface vrim_rf_if;
  import vrim_pkg::*;
  logic [NRD-1:0][RIDX_W-1:0] raddr;
  logic [NRD-1:0][XLEN-1:0] rdata;
  logic [NLANE-1:0] we;
  logic [NLANE-1:0][RIDX_W-1:0] waddr;
  logic [NLANE-1:0][XLEN-1:0] wdata;
  logic wb_over;

  modport core (output raddr, we, waddr, wdata, input rdata, wb_over);
  modport rf (input raddr, we, waddr, wdata, output rdata, wb_over);
endinterface : vrim_rf_if

/* vrim_regfile.sv */
`timescale 1ns/1ps
module vrim_regfile
  import vrim_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Core side
  vrim_rf_if.rf rf
);

  typedef struct packed {
    logic [NREG-1:0][XLEN-1:0] regs;
  } vrim_rf_s;

  vrim_rf_s st_reg;
  vrim_rf_s st_next;

  // Read ports: constants for the two lowest registers
  always_comb
  begin
    for (int i = 0; i < NRD; i++)
    begin
      // RQ2: zero reads zero
      if (rf.raddr[i] == 7'h00)
        rf.rdata[i] = CONST_ZERO;
      // RQ3: one reads one
      else if (rf.raddr[i] == 7'h01)
        rf.rdata[i] = CONST_ONE;
      // RQ5: plain general storage
      else
        rf.rdata[i] = st_reg.regs[rf.raddr[i]];
    end
  end

  // Write lanes, at most five accepted per cycle
  always_comb
  begin
    int cnt;
    cnt = 0;
    st_next = st_reg;
    for (int l = 0; l < NLANE; l++)
    begin
      if (rf.we[l])
      begin
        // RQ17: lanes past five dropped
        if (cnt < WB_LIMIT && rf.waddr[l] > 7'h01)
          // RQ21: constant registers protected
          st_next.regs[rf.waddr[l]] = rf.wdata[l];
        cnt = cnt + 1;
      end
    end
    // RQ19: too many write backs
    rf.wb_over = (cnt > WB_LIMIT);
  end

  // RQ1: storage of 128 words
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

endmodule : vrim_regfile

/* vrim_tally.sv */
`timescale 1ns/1ps
module vrim_tally
  import vrim_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Mode and stall
  input wire logic count_all,
  input wire logic stalled,
  // Count
  output logic [63:0] tally
);

  typedef struct packed {
    logic [63:0] cnt;
  } vrim_tally_s;

  vrim_tally_s st_reg;
  vrim_tally_s st_next;

  // RQ18: count all or unstalled cycles
  always_comb
  begin
    st_next = st_reg;
    if (count_all || !stalled)
      st_next.cnt = st_reg.cnt + 64'h0000_0000_0000_0001;
  end

  // RQ6: counter starts at reset
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_reg <= '{cnt: TALLY_RESET};
    else if (ce)
      st_reg <= st_next;
  end

  assign tally = st_reg.cnt;

endmodule : vrim_tally

/* vrim_core.sv */
`timescale 1ns/1ps
// Contract
// RQ1: 128 general registers, 32 bits each
// RQ2: register zero always reads 0x0
// RQ3: register one always reads 0x1
// RQ4: code never writes register zero or one
// RQ5: registers two upward are plain storage
// RQ6: 64-bit cycle tally counts from reset
// RQ7: resume target holds interrupted branch target
// RQ8: block start holds uninterrupted branch target
// RQ9: one five-slot instruction issued per cycle
// RQ10: false guard means no effect at all
// RQ11: add result usable next cycle only
// RQ12: word load result usable three cycles later
// RQ13: load address is base plus displacement
// RQ14: jump-if-false needs true guard, false condition
// RQ15: taken branch has three delay slots
// RQ16: code packs two loads per instruction
// RQ17: code keeps write backs to five
// RQ18: count-stalls bit picks tally counting mode
// RQ19: over five write backs sets error flag
// RQ20: resume target updated at every jump; code updates it only when a taken jump transfers
// RQ21: writes to constant registers are suppressed
module vrim_core
  import vrim_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Instruction fetch
  output logic [XLEN-1:0] fetch_pc,
  input wire logic instr_valid,
  input wire logic [NSLOT*SLOT_W-1:0] instr_word,
  // Interrupt request sampled at taken-jump transfers
  input wire logic irq_req,
  // Data load ports
  output logic [NLD-1:0] ld_req,
  output logic [NLD-1:0][XLEN-1:0] ld_addr,
  input wire logic [NLD-1:0][XLEN-1:0] ld_rdata,
  // Status
  output logic exc_taken,
  output logic wb_error
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Program counter and special registers
    logic [XLEN-1:0] pc;
    logic [XLEN-1:0] psw;
    logic [XLEN-1:0] resume_pc;
    logic [XLEN-1:0] block_pc;
    // Branch sequencer: state, slots left, pending target
    vrim_br_e br;
    logic [1:0] br_cnt;
    logic [XLEN-1:0] br_target;
    // Load pipeline: request stage, then return stage
    logic [NLD-1:0] ld_req;
    logic [NLD-1:0][XLEN-1:0] ld_addr;
    logic [NLD-1:0][RIDX_W-1:0] ld_dst1;
    logic [NLD-1:0] ld_vld2;
    logic [NLD-1:0][RIDX_W-1:0] ld_dst2;
    // One-cycle exception pulse
    logic exc;
  } vrim_core_s;

  vrim_core_s st_reg;
  vrim_core_s st_next;

  // Local nets
  vrim_rf_if rf ();
  logic [63:0] tally;
  logic issue;
  vrim_slot_s [NSLOT-1:0] slots;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Register file, r0 and r1 fixed in hardware
  vrim_regfile u_regfile (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .rf(rf.rf)
  );

  // Cycle tally, mode from the count-stalls bit
  vrim_tally u_tally (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .count_all(st_reg.psw[PSW_CS_BIT]),
    .stalled(!instr_valid),
    .tally(tally)
  );

  // RQ9: one instruction each valid cycle
  assign issue = instr_valid;
  assign slots = instr_word;

  // ----------------------------------------------------------------
  // Operand reads and special register mux
  // ----------------------------------------------------------------
  // Read addresses: guard, first and second source per slot
  always_comb
  begin
    for (int i = 0; i < NSLOT; i++)
    begin
      rf.raddr[3*i] = slots[i].guard;
      rf.raddr[3*i+1] = slots[i].src1;
      rf.raddr[3*i+2] = slots[i].src2;
    end
  end

  // Special register read mux
  function automatic logic [XLEN-1:0] spec_read(
    input logic [8:0] sel,
    input vrim_core_s s,
    input logic [63:0] t
  );
    logic [XLEN-1:0] v;
    v = CONST_ZERO;
    unique case (sel)
      SEL_PSW: v = s.psw;
      SEL_RESUME: v = s.resume_pc;
      SEL_BLOCK: v = s.block_pc;
      SEL_TALLY_LO: v = t[31:0];
      SEL_TALLY_HI: v = t[63:32];
      // Unused selects read as zero
      default: v = CONST_ZERO;
    endcase
    return v;
  endfunction : spec_read

  // ----------------------------------------------------------------
  // Issue, branch sequencing and special registers
  // ----------------------------------------------------------------
  always_comb
  begin
    // Per-instruction scratch
    int ln;
    logic take;
    logic [XLEN-1:0] tgt;
    logic sw_en;
    logic [8:0] sw_sel;
    logic [XLEN-1:0] sw_val;
    logic grd;
    logic [XLEN-1:0] a;
    logic [XLEN-1:0] b;
    // Defaults: hold state, no writes
    ln = 0;
    take = 1'b0;
    tgt = CONST_ZERO;
    sw_en = 1'b0;
    sw_sel = SEL_PSW;
    sw_val = CONST_ZERO;
    grd = 1'b0;
    a = CONST_ZERO;
    b = CONST_ZERO;
    st_next = st_reg;
    st_next.exc = 1'b0;
    st_next.ld_req = '0;
    // Load pipeline advances on stalls too
    // RQ12: load data lands two cycles on
    st_next.ld_vld2 = st_reg.ld_req;
    st_next.ld_dst2 = st_reg.ld_dst1;
    rf.we = '0;
    rf.waddr = '0;
    rf.wdata = '0;
    // Nothing issues on a stall cycle
    if (issue)
    begin
      for (int i = 0; i < NSLOT; i++)
      begin
        grd = rf.rdata[3*i][0];
        a = rf.rdata[3*i+1];
        b = rf.rdata[3*i+2];
        // RQ10: guard gates every effect
        if (grd)
        begin
          unique case (slots[i].op)
            OP_IADD:
            begin
              // RQ11: written at the issue edge
              rf.we[i] = 1'b1;
              rf.waddr[i] = slots[i].dst;
              rf.wdata[i] = a + b;
            end
            OP_WORD_LOAD_DISP:
            begin
              // Load lanes fill from zero in slot order
              // RQ16: third load in a word dropped
              if (ln < NLD)
              begin
                st_next.ld_req[ln] = 1'b1;
                // RQ13: base plus signed displacement
                st_next.ld_addr[ln] = a + {{23{slots[i].imm[8]}},
                                           slots[i].imm};
                st_next.ld_dst1[ln] = slots[i].dst;
                ln = ln + 1;
              end
            end
            OP_JMPF:
            begin
              // Lowest slot wins, later jumps ignored
              // RQ14: jump when condition is false
              if (!a[0] && !take)
              begin
                take = 1'b1;
                tgt = b;
              end
            end
            OP_RDSPEC:
            begin
              // Special register copied into dst
              rf.we[i] = 1'b1;
              rf.waddr[i] = slots[i].dst;
              rf.wdata[i] = spec_read(slots[i].imm, st_reg, tally);
            end
            OP_WRSPEC:
            begin
              // Highest slot wins, applied below
              sw_en = 1'b1;
              sw_sel = slots[i].imm;
              sw_val = a;
            end
            OP_NOP:
            begin
            end
            default:
            begin
            end
          endcase
        end
      end
      // RQ15: three delay slots before transfer
      unique case (st_reg.br)
        BR_IDLE:
        begin
          // Sequential fetch; a taken jump arms the counter
          st_next.pc = st_reg.pc + INSTR_STEP;
          if (take)
          begin
            st_next.br = BR_DELAY;
            st_next.br_cnt = BR_DELAY_SLOTS;
            st_next.br_target = tgt;
          end
        end
        BR_DELAY:
        begin
          if (st_reg.br_cnt == 2'h1)
          begin
            // Last delay slot issued: transfer now
            st_next.br = BR_IDLE;
            // RQ20: every taken jump outside delay slots updates resume target
            st_next.resume_pc = st_reg.br_target;
            // Request sampled only at the transfer edge
            if (irq_req)
            begin
              // RQ7: interrupted jump keeps target
              st_next.pc = EXC_VECTOR;
              st_next.exc = 1'b1;
            end
            else
            begin
              // RQ8: uninterrupted jump marks block
              st_next.block_pc = st_reg.br_target;
              st_next.pc = st_reg.br_target;
            end
          end
          else
          begin
            // Delay slots count issued instructions only
            st_next.br_cnt = st_reg.br_cnt - 2'h1;
            st_next.pc = st_reg.pc + INSTR_STEP;
          end
        end
      endcase
    end
    // Software moves take precedence over jump updates
    if (sw_en)
    begin
      unique case (sw_sel)
        SEL_PSW: st_next.psw = sw_val;
        SEL_RESUME: st_next.resume_pc = sw_val;
        SEL_BLOCK: st_next.block_pc = sw_val;
        default:
        begin
        end
      endcase
    end
    // Return data must stand the cycle after the request
    // Load return lanes follow the five slot lanes
    for (int k = 0; k < NLD; k++)
    begin
      rf.we[NSLOT+k] = st_reg.ld_vld2[k];
      rf.waddr[NSLOT+k] = st_reg.ld_dst2[k];
      rf.wdata[NSLOT+k] = ld_rdata[k];
    end
    // Write-back error is sticky until software clears it
    // RQ19: hardware set wins over software
    if (rf.wb_over)
      st_next.psw[PSW_WBE_BIT] = 1'b1;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Registers advance only while enabled
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg.pc <= RESET_PC;
      st_reg.psw <= PSW_RESET;
      st_reg.resume_pc <= CONST_ZERO;
      st_reg.block_pc <= CONST_ZERO;
      st_reg.br <= BR_IDLE;
      st_reg.br_cnt <= 2'h0;
      st_reg.br_target <= CONST_ZERO;
      st_reg.ld_req <= '0;
      st_reg.ld_addr <= '0;
      st_reg.ld_dst1 <= '0;
      st_reg.ld_vld2 <= '0;
      st_reg.ld_dst2 <= '0;
      st_reg.exc <= 1'b0;
    end
    else if (ce)
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Outputs straight from state
  assign fetch_pc = st_reg.pc;
  assign ld_req = st_reg.ld_req;
  assign ld_addr = st_reg.ld_addr;
  assign exc_taken = st_reg.exc;
  assign wb_error = st_reg.psw[PSW_WBE_BIT];

endmodule : vrim_core

/* vrim_core_assertions.sv */
`timescale 1ns/1ps
module vrim_core_assertions
  import vrim_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Issue side
  input wire logic ce,
  input wire logic [XLEN-1:0] fetch_pc,
  input wire logic instr_valid,
  input wire logic [NSLOT*SLOT_W-1:0] instr_word,
  input wire logic irq_req,
  // Loads and status
  input wire logic [NLD-1:0] ld_req,
  input wire logic [NLD-1:0][XLEN-1:0] ld_addr,
  input wire logic [NLD-1:0][XLEN-1:0] ld_rdata,
  input wire logic exc_taken,
  input wire logic wb_error
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Issue, and issue with only slot zero in use
  logic iss;
  logic solo;
  assign iss = ce && instr_valid;
  assign solo = iss && instr_word[199:40] == 160'h0;

  // Slot zero: load off r0, load under false guard, taken jump
  sequence zero_load;
    solo && instr_word[39:23] == {3'h2, 7'h01, 7'h00};
  endsequence
  sequence off_load;
    solo && instr_word[39:30] == {3'h2, 7'h00};
  endsequence
  sequence br_take;
    solo && instr_word[39:23] == {3'h3, 7'h01, 7'h00};
  endsequence

  stall_hold_a: assert property (
    ce && !instr_valid |=> $stable(fetch_pc))
    else $error("fetch address moved while stalled");
  empty_issue_a: assert property (
    iss && instr_word == '0 |=> ld_req == 2'h0)
    else $error("load request from an empty instruction");
  load_addr_a: assert property (
    zero_load |=> ld_req[0] && ld_addr[0] ==
      {{23{$past(instr_word[8])}}, $past(instr_word[8:0])})
    else $error("load address is not base plus displacement");
  guard_off_a: assert property (
    off_load |=> ld_req == 2'h0)
    else $error("load issued under a false guard");
  load_pulse_a: assert property (
    ld_req[0] && ce && !instr_valid |=> !ld_req[0])
    else $error("load request longer than one cycle");
  wb_hold_a: assert property (
    wb_error && ce && !instr_valid |=> wb_error)
    else $error("write-back error flag dropped without a write");
  wb_cause_a: assert property (
    $rose(wb_error) |-> $past(iss))
    else $error("write-back error flag set without an issue");
  exc_vec_a: assert property (
    $rose(exc_taken) |-> fetch_pc == EXC_VECTOR && $past(irq_req))
    else $error("exception without request or vector");
  exc_pulse_a: assert property (
    exc_taken && ce |=> !exc_taken)
    else $error("exception pulse longer than one cycle");
  br_step_a: assert property (
    br_take |=> fetch_pc == $past(fetch_pc) + INSTR_STEP)
    else $error("first delay slot not sequential");
  br_slots_a: assert property (
    br_take ##1 iss |=> fetch_pc == $past(fetch_pc, 2) + 32'h0000_0040)
    else $error("second delay slot not sequential");
endmodule : vrim_core_assertions

bind vrim_core vrim_core_assertions vrim_core_assertions_i (.ref_clk,
  .sys_rst, .ce, .fetch_pc, .instr_valid, .instr_word, .irq_req, .ld_req,
  .ld_addr, .ld_rdata, .exc_taken, .wb_error);

/* vrim_core_tb.sv */
`timescale 1ns/1ps
module vrim_core_tb
  import vrim_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk, sys_rst, ce, instr_valid, irq_req, exc_taken, wb_error;
  logic [NSLOT*SLOT_W-1:0] instr_word;
  logic [XLEN-1:0] fetch_pc, p, t0;
  logic [NLD-1:0] ld_req;
  logic [NLD-1:0][XLEN-1:0] ld_addr, ld_rdata;
  vrim_slot_s ia;
  int fail_count, compares;
  typedef struct packed {
    vrim_slot_s a;
    logic [6:0] r;
    logic [31:0] e;
  } vrim_row_s;
  vrim_row_s rows [7];

  // Design under test
  vrim_core vrim_core_i (.ref_clk, .sys_rst, .ce, .fetch_pc, .instr_valid,
    .instr_word, .irq_req, .ld_req, .ld_addr, .ld_rdata, .exc_taken,
    .wb_error);

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Slot builders and bus tasks
  // ----------------------------------------------------------------
  function automatic vrim_slot_s sl(vrim_op_e o, logic [6:0] g, a, b, d,
    logic [8:0] m);
    return '{o, g, a, b, d, m};
  endfunction : sl

  function automatic vrim_slot_s ad(logic [6:0] g, a, b, d);
    return sl(OP_IADD, g, a, b, d, 9'h000);
  endfunction : ad

  function automatic vrim_slot_s jf(logic [6:0] g, c, t);
    return sl(OP_JMPF, g, c, t, 7'h00, 9'h000);
  endfunction : jf

  // Load probe, result lands in scratch r100
  // probe writes r100
  function automatic vrim_slot_s pr(logic [6:0] r, logic [8:0] m);
    return sl(OP_WORD_LOAD_DISP, 7'h01, r, 7'h00, 7'h64, m);
  endfunction : pr

  task automatic chk(logic [63:0] s, e);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Issue one instruction at the next rising edge
  // two slots, rest empty
  task automatic step(vrim_slot_s a = '0, vrim_slot_s b = '0);
    instr_word = {120'h0, b, a};
    instr_valid = 1'b1;
    @(negedge ref_clk);
  endtask : step

  task automatic idle(int n);
    instr_valid = 1'b0;
    repeat (n) @(negedge ref_clk);
  endtask : idle

  // Register value seen as a load address
  task automatic rd(logic [6:0] r, logic [8:0] m, logic [31:0] e);
    step(pr(r, m));
    chk({ld_req[0], ld_addr[0]}, {1'b1, e});
  endtask : rd

  task automatic rsd(logic [8:0] m, logic [31:0] e);
    step(sl(OP_RDSPEC, 7'h01, 7'h00, 7'h00, 7'h0c, m));
    rd(7'h0c, 9'h000, e);
  endtask : rsd

  // Tally growth across three stalled cycles
  task automatic tt(logic [31:0] e);
    step(sl(OP_RDSPEC, 7'h01, 7'h00, 7'h00, 7'h0a, SEL_TALLY_LO));
    idle(3);
    step(sl(OP_RDSPEC, 7'h01, 7'h00, 7'h00, 7'h0b, SEL_TALLY_LO));
    step(pr(7'h0a, 9'h000));
    t0 = ld_addr[0];
    step(pr(7'h0b, 9'h000));
    chk(ld_addr[0] - t0, e);
  endtask : tt

  task automatic fin(string s);
    $display("%s test done, %0d checks", s, compares);
  endtask : fin

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // Watchdog
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    instr_valid = 1'b0;
    irq_req = 1'b0;
    instr_word = '0;
    ld_rdata = {2{32'h0000_0400}};
    ia = ad(7'h01, 7'h02, 7'h02, 7'h14);
    rows = '{
      '{ad(7'h01, 7'h01, 7'h01, 7'h02), 7'h02, 32'h0000_0002},
      '{'0, 7'h00, 32'h0},
      '{'0, 7'h01, 32'h0000_0001},
      '{ad(7'h00, 7'h02, 7'h02, 7'h03), 7'h03, 32'h0},
      '{ad(7'h01, 7'h02, 7'h02, 7'h00), 7'h00, 32'h0},
      '{ad(7'h01, 7'h02, 7'h01, 7'h7f), 7'h7f, 32'h0000_0003},
      '{ad(7'h7f, 7'h7f, 7'h7f, 7'h04), 7'h04, 32'h0000_0006}};
    repeat (10) @(negedge ref_clk);
    chk({fetch_pc, ld_req, exc_taken, wb_error}, 36'h0);
    sys_rst = 1'b0;
    rsd(SEL_PSW, PSW_RESET);
    rsd(SEL_TALLY_HI, 32'h0);
    fin("reset");
    foreach (rows[i])
    begin
      step(rows[i].a);
      rd(rows[i].r, 9'h000, rows[i].e);
    end
    fin("table");
    // Add result unseen in its own instruction
    step(pr(7'h05, 9'h000), ad(7'h01, 7'h02, 7'h02, 7'h05));
    chk(ld_addr[0], 32'h0);
    rd(7'h05, 9'h000, 32'h0000_0004);
    rd(7'h7f, 9'h1fc, 32'hffff_ffff);
    rd(7'h00, 9'h1fc, 32'hffff_fffc);
    step(sl(OP_WORD_LOAD_DISP, 7'h00, 7'h02, 7'h00, 7'h64, 9'h000));
    chk(ld_req, 2'h0);
    // Load result visible only three cycles on
    step(sl(OP_WORD_LOAD_DISP, 7'h01, 7'h02, 7'h00, 7'h06, 9'h000));
    idle(1);
    rd(7'h06, 9'h000, 32'h0);
    rd(7'h06, 9'h000, 32'h0000_0400);
    fin("load");
    // Taken jump through three delay slots
    p = fetch_pc;
    step(jf(7'h01, 7'h00, 7'h06));
    for (int k = 1; k < 4; k++)
    begin
      chk(fetch_pc, p + 32'h0000_0020 * k);
      step(ad(7'h01, 7'h02, 7'h02, 7'h07));
    end
    chk(fetch_pc, 32'h0000_0400);
    rd(7'h07, 9'h000, 32'h0000_0004);
    rsd(SEL_BLOCK, 32'h0000_0400);
    rsd(SEL_RESUME, 32'h0000_0400);
    // Jumps with true condition or false guard fall through
    p = fetch_pc;
    step(jf(7'h01, 7'h01, 7'h06));
    step(jf(7'h00, 7'h00, 7'h06));
    step();
    step();
    step();
    chk(fetch_pc, p + 32'h0000_00a0);
    // Interrupted jump to r2
    step(jf(7'h01, 7'h00, 7'h02));
    step();
    step();
    irq_req = 1'b1;
    step();
    irq_req = 1'b0;
    chk({exc_taken, fetch_pc}, {1'b1, EXC_VECTOR});
    rsd(SEL_RESUME, 32'h0000_0002);
    rsd(SEL_BLOCK, 32'h0000_0400);
    fin("branch");
    tt(32'h0000_0004);
    // Write-back lanes at and above the limit
    step(pr(7'h02, 9'h000));
    step();
    instr_word = {40'h0, {4{ia}}};
    @(negedge ref_clk);
    chk(wb_error, 1'b0);
    step(pr(7'h02, 9'h000), pr(7'h02, 9'h000));
    chk({ld_req, ld_addr[1]}, {2'h3, 32'h0000_0002});
    step();
    instr_word = {5{ia}};
    @(negedge ref_clk);
    idle(2);
    chk(wb_error, 1'b1);
    step(sl(OP_WRSPEC, 7'h01, 7'h00, 7'h00, 7'h00, SEL_PSW));
    chk(wb_error, 1'b0);
    tt(32'h0000_0001);
    fin("status");
    // Frozen while the clock enable is low
    ce = 1'b0;
    p = fetch_pc;
    step(ad(7'h01, 7'h02, 7'h02, 7'h08));
    chk(fetch_pc, p);
    ce = 1'b1;
    rd(7'h08, 9'h000, 32'h0);
    fin("enable");
    // Second reset in mid-run, then release
    sys_rst = 1'b1;
    @(negedge ref_clk);
    chk({fetch_pc, wb_error}, 33'h0);
    sys_rst = 1'b0;
    rsd(SEL_PSW, PSW_RESET);
    rd(7'h02, 9'h000, 32'h0);
    fin("second reset");
    conclude();
  end
endmodule : vrim_core_tb
